// ---- verilog/eew_pkg.sv ----
// constants and types shared by the serial eeprom data path
// assumes a 200 MHz core clock and a free-standing serial clock
package eew_pkg;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ   = 200;
    localparam int T_CSL_NS  = 250;
    // least time, so rounded up
    localparam int CSL_CYC   = (T_CSL_NS * CLK_MHZ + 999) / 1000;
    localparam int T_PROG_US = 4000;
    localparam int PROG_CYC  = T_PROG_US * CLK_MHZ;

    // -------------------------------------------------------------
    // organisation and frame layout
    // -------------------------------------------------------------
    localparam int         MEM_BYTES  = 128;
    localparam int         FIFO_DEPTH = 16;
    localparam logic [4:0] ALEN16     = 5'h06;
    localparam logic [4:0] ALEN8      = 5'h07;
    localparam logic [4:0] DLEN16     = 5'h10;
    localparam logic [4:0] DLEN8      = 5'h08;
    localparam logic [4:0] OP_BITS    = 5'h02;
    localparam logic [5:0] CSL_SAT    = 6'(CSL_CYC);
    localparam logic       WIDTH_RST  = 1'h1;

    // -------------------------------------------------------------
    // opcodes
    // -------------------------------------------------------------
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        L_IDLE, L_OP, L_ADDR, L_DATA, L_READ, L_DONE
    } eew_link_state_t;

    typedef enum logic {P_IDLE, P_RUN} eew_prog_state_t;

    typedef struct packed {
        logic [1:0]  op;
        logic        wide;
        logic [6:0]  addr;
        logic [15:0] data;
    } eew_cmd_t;

endpackage

// ---- verilog/eew_sync.sv ----
// two flip-flop level synchroniser, two stages for each bit of the vector
// assumes each bit is a level that holds for several destination edges
`timescale 1ns/100ps
module eew_sync
    import eew_pkg::*;
#(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } eew_sync_st_t;

    eew_sync_st_t s_reg;
    eew_sync_st_t s_next;

    // the first stage feeds only the second
    always_comb begin
        s_next      = s_reg;
        s_next.meta = async_in;
        s_next.held = s_reg.meta;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= {RST_VAL, RST_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.held;

endmodule

// ---- verilog/eew_fifo.sv ----
// synchronous fifo for queued programming commands
// assumes both sides run on the core clock
`timescale 1ns/100ps
module eew_fifo
    import eew_pkg::*;
#(
    parameter int WIDTH = 26,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } eew_fifo_st_t;

    eew_fifo_st_t     f_reg;
    eew_fifo_st_t     f_next;
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      fill;
    logic             push;
    logic             pop;

    assign fill      = f_reg.wp - f_reg.rp;
    assign in_ready  = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = store[f_reg.rp[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        f_next = f_reg;
        if (push) begin
            f_next.wp = f_reg.wp + (AW+1)'(1);
        end
        if (pop) begin
            f_next.rp = f_reg.rp + (AW+1)'(1);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            store[f_reg.wp[AW-1:0]] <= in_data;
        end
    end

endmodule

// ---- verilog/eew_top.sv ----
// serial eeprom data pins: frame decode, read shift-out, status output
// assumes the master owns serial_clock, chip_select and serial_in_line;
// serial_out is resolved with its enable by the surrounding wiring
//
// Functional notes
// - master sends start, opcode, address, data; device samples each with clock.
// - read data leaves one bit per serial clock, launched after rising edge.
// - status appears on the output during an erase or write cycle.
// - status only after select held low minimum time, then raised again.
// - select low or high throughout the cycle: no status driven.
// - output is high impedance unless reading or showing status.
// - width select high gives 16-bit words, low gives 8-bit words.
// - status low while programming, high once ready.
// - read sends one zero bit, then 16 or 8 data bits.
// - select low holds the instruction decoder in reset.
// - opcode, address and data captured on serial clock rising edge.
`timescale 1ns/100ps
module eew_top
    import eew_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic serial_clock,
    input  wire logic chip_select,
    input  wire logic serial_in_line,
    input  wire logic word_width_select,
    output      logic serial_out,
    output      logic serial_out_oe_n
);

    // -------------------------------------------------------------
    // link domain state
    // -------------------------------------------------------------
    typedef struct packed {
        eew_link_state_t state;
        logic [4:0]      cnt;
        logic [1:0]      op;
        logic [6:0]      addr;
        logic [15:0]     shr;
        logic            out_bit;
        logic            out_en;
    } eew_frame_t;

    // survives deselect so the core can still pick it up
    typedef struct packed {
        eew_cmd_t   cmd;
        logic       cmd_tgl;
        logic       rq_tgl;
        logic [4:0] rq_grp;
        logic       rq_wide;
    } eew_xfer_t;

    typedef struct packed {
        logic            cs_d;
        logic [5:0]      low_cnt;
        logic            cmd_seen;
        logic            rq_seen;
        logic            rd_ack;
        logic            pend;
        eew_cmd_t        hold;
        eew_prog_state_t eng;
        logic [23:0]     prog_cnt;
        eew_cmd_t        cur;
        logic [63:0]     rd_bus;
        logic            show;
        logic            dout;
        logic            oe_n;
    } eew_core_t;

    eew_frame_t lr, ln;
    eew_xfer_t  br, bn;
    eew_core_t  cr, cn;

    logic       link_rst_n;
    logic       ack_s;
    logic       wide_s;
    logic [4:0] core_s;
    logic       cs_s;
    logic       cmd_s;
    logic       rq_s;
    logic       rbit_s;
    logic       ren_s;
    logic [4:0] alen;
    logic [4:0] dlen;
    logic [15:0] unit;

    // select low clears the decoder; glitch-free as both inputs are static
    // decoder reset
    assign link_rst_n = reset_n & chip_select;

    eew_sync #(.WIDTH(2), .RST_VAL({1'h0, WIDTH_RST})) u_link_sync (
        .clock    (serial_clock),
        .reset_n  (reset_n),
        .async_in ({cr.rd_ack, word_width_select}),
        .sync_out ({ack_s, wide_s})
    );

    eew_sync #(.WIDTH(5)) u_core_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in ({chip_select, br.cmd_tgl, br.rq_tgl,
                    lr.out_bit, lr.out_en}),
        .sync_out (core_s)
    );
    assign {cs_s, cmd_s, rq_s, rbit_s, ren_s} = core_s;

    // -------------------------------------------------------------
    // link frame decoder
    // -------------------------------------------------------------
    // bit counts follow width
    assign alen = wide_s ? ALEN16 : ALEN8;
    assign dlen = wide_s ? DLEN16 : DLEN8;

    // read words are fetched two address bits early so they have crossed
    // before the first data bit; a serial clock much faster than the
    // bench rate would outrun this and read back all ones
    always_comb begin
        unit = cr.rd_bus[{lr.addr[1:0], 4'h0} +: 16];
        if (ack_s != br.rq_tgl) begin
            unit = 16'hFFFF;
        end else if (!wide_s) begin
            unit = {unit[7:0], 8'h00};
        end
    end

    always_comb begin
        ln = lr;
        bn = br;
        unique case (lr.state)
            L_IDLE: begin
                if (serial_in_line) begin
                    ln.state = L_OP;
                end
            end
            L_OP: begin
                ln.op  = {lr.op[0], serial_in_line};
                ln.cnt = lr.cnt + 5'h01;
                if (ln.cnt == OP_BITS) begin
                    ln.state = L_ADDR;
                    ln.cnt   = 5'h00;
                end
            end
            L_ADDR: begin
                ln.addr = {lr.addr[5:0], serial_in_line};
                ln.cnt  = lr.cnt + 5'h01;
                if (lr.op == OP_READ && ln.cnt == alen - 5'h02) begin
                    bn.rq_tgl  = ~br.rq_tgl;
                    bn.rq_grp  = ln.addr[4:0];
                    bn.rq_wide = wide_s;
                end
                if (ln.cnt == alen) begin
                    ln.cnt   = 5'h00;
                    ln.state = L_DONE;
                    if (lr.op == OP_READ) begin
                        ln.state   = L_READ;
                        ln.out_en  = 1'h1;
                        ln.out_bit = 1'h0;
                    end else if (lr.op == OP_WRITE) begin
                        ln.state = L_DATA;
                    end else if (lr.op == OP_ERASE) begin
                        bn.cmd     = '{lr.op, wide_s, ln.addr, 16'hFFFF};
                        bn.cmd_tgl = ~br.cmd_tgl;
                    end
                end
            end
            L_DATA: begin
                ln.shr = {lr.shr[14:0], serial_in_line};
                ln.cnt = lr.cnt + 5'h01;
                if (ln.cnt == dlen) begin
                    bn.cmd     = '{lr.op, wide_s, lr.addr, ln.shr};
                    bn.cmd_tgl = ~br.cmd_tgl;
                    ln.state   = L_DONE;
                end
            end
            L_READ: begin
                ln.cnt = lr.cnt + 5'h01;
                if (lr.cnt == 5'h00) begin
                    ln.out_bit = unit[15];
                    ln.shr     = {unit[14:0], 1'h0};
                end else if (lr.cnt == dlen) begin
                    ln.out_en  = 1'h0;
                    ln.out_bit = 1'h0;
                    ln.state   = L_DONE;
                end else begin
                    ln.out_bit = lr.shr[15];
                    ln.shr     = {lr.shr[14:0], 1'h0};
                end
            end
            L_DONE: begin
            end
        endcase
    end

    always_ff @(posedge serial_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lr <= '{L_IDLE, 5'h00, 2'h0, 7'h00, 16'h0000, 1'h0, 1'h0};
        end else begin
            lr <= ln;
        end
    end

    always_ff @(posedge serial_clock or negedge reset_n) begin
        if (!reset_n) begin
            br <= '0;
        end else begin
            br <= bn;
        end
    end

    // -------------------------------------------------------------
    // core: command queue, array and programming timer
    // -------------------------------------------------------------
    logic [7:0]  mem [MEM_BYTES];
    logic [63:0] rd_fill;
    logic [6:0]  u;
    logic        q_valid;
    logic        q_ready;
    logic        q_pop;
    eew_cmd_t    q_data;
    logic        busy;
    logic        wr_en;

    eew_fifo #(.WIDTH($bits(eew_cmd_t)), .DEPTH(FIFO_DEPTH)) u_queue (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (cr.pend && !cs_s),
        .in_ready  (q_ready),
        .in_data   (cr.hold),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (q_data)
    );

    assign q_pop = (cr.eng == P_IDLE);
    assign busy  = (cr.eng == P_RUN) || q_valid || cr.pend;
    assign wr_en = (cr.eng == P_RUN) && (cr.prog_cnt == 24'h000000);

    always_comb begin
        rd_fill = '0;
        u       = '0;
        for (int i = 0; i < 4; i++) begin
            u = {br.rq_grp, 2'(i)};
            if (br.rq_wide) begin
                rd_fill[16*i +: 16] = {mem[{u[5:0], 1'h0}],
                                       mem[{u[5:0], 1'h1}]};
            end else begin
                rd_fill[16*i +: 16] = {8'h00, mem[u]};
            end
        end
    end

    always_comb begin
        cn          = cr;
        cn.cs_d     = cs_s;
        cn.cmd_seen = cmd_s;
        cn.rq_seen  = rq_s;
        if (rq_s != cr.rq_seen) begin
            cn.rd_bus = rd_fill;
            cn.rd_ack = rq_s;
        end
        // while a command waits for room, later ones are refused
        if (cmd_s != cr.cmd_seen && !cr.pend) begin
            cn.pend = 1'h1;
            cn.hold = br.cmd;
        end else if (cr.pend && !cs_s && q_ready) begin
            cn.pend = 1'h0;
        end
        unique case (cr.eng)
            P_IDLE: begin
                if (q_valid) begin
                    cn.eng      = P_RUN;
                    cn.cur      = q_data;
                    cn.prog_cnt = 24'(PROG_CYCLES - 1);
                end
            end
            P_RUN: begin
                cn.prog_cnt = cr.prog_cnt - 24'h000001;
                if (wr_en) begin
                    cn.eng = P_IDLE;
                end
            end
        endcase
        cn.low_cnt = 6'h00;
        if (!cs_s) begin
            cn.low_cnt = (cr.low_cnt == CSL_SAT) ? CSL_SAT
                                                 : cr.low_cnt + 6'h01;
        end
        if (!cs_s) begin
            cn.show = 1'h0;
        end else if (!cr.cs_d && cr.low_cnt == CSL_SAT && busy) begin
            cn.show = 1'h1;
        end
        if (cn.show) begin
            cn.oe_n = 1'h0;
            cn.dout = !busy;
        end else if (cs_s && ren_s) begin
            cn.oe_n = 1'h0;
            cn.dout = rbit_s;
        end else begin
            cn.oe_n = 1'h1;
            cn.dout = 1'h0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cr      <= '0;
            cr.oe_n <= 1'h1;
        end else begin
            cr <= cn;
        end
    end

    always_ff @(posedge clock) begin
        if (wr_en) begin
            if (cr.cur.wide) begin
                mem[{cr.cur.addr[5:0], 1'h0}] <= cr.cur.data[15:8];
                mem[{cr.cur.addr[5:0], 1'h1}] <= cr.cur.data[7:0];
            end else begin
                mem[cr.cur.addr] <= cr.cur.data[7:0];
            end
        end
    end

    assign serial_out      = cr.dout;
    assign serial_out_oe_n = cr.oe_n;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence s_low_then_rise;
        !cs_s && !cr.cs_d ##1 cs_s && cr.low_cnt == CSL_SAT;
    endsequence

    chk_status_busy_low: assert property (
        @(posedge clock) disable iff (!reset_n)
        cr.show && $past(busy) |-> !serial_out && !serial_out_oe_n)
        else $error("status not low while busy");

    chk_status_ready_high: assert property (
        @(posedge clock) disable iff (!reset_n)
        cr.show && !$past(busy) |-> serial_out && !serial_out_oe_n)
        else $error("status not high when ready");

    chk_status_needs_rise: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(cr.show) |-> $past(cr.cs_d == 1'h0 && cs_s
                                 && cr.low_cnt == CSL_SAT))
        else $error("status shown without a qualified select rise");

    chk_status_rise_shows: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_low_then_rise ##0 busy |=> cr.show && !serial_out_oe_n)
        else $error("status missing after select rise");

    chk_deselect_hiz: assert property (
        @(posedge clock) disable iff (!reset_n)
        !cs_s |=> serial_out_oe_n)
        else $error("output driven while deselected");

    chk_read_dummy_zero: assert property (
        @(posedge serial_clock) disable iff (!link_rst_n)
        $rose(lr.out_en) |-> !lr.out_bit && lr.state == L_READ)
        else $error("read does not start with a zero bit");

    chk_read_shift_bit: assert property (
        @(posedge serial_clock) disable iff (!link_rst_n)
        lr.state == L_READ && lr.cnt != 5'h00 && lr.cnt != dlen
        |=> lr.out_bit == $past(lr.shr[15]))
        else $error("read bit not taken from shifter");

    chk_read_length: assert property (
        @(posedge serial_clock) disable iff (!link_rst_n)
        $fell(lr.out_en) |-> $past(lr.cnt) == (wide_s ? DLEN16 : DLEN8))
        else $error("read word length wrong for width");

    chk_opcode_sample: assert property (
        @(posedge serial_clock) disable iff (!link_rst_n)
        lr.state == L_OP |=> lr.op[0] == $past(serial_in_line))
        else $error("opcode bit not sampled on rising edge");

endmodule

// ---- sim/eew_master.sv ----
// behavioural three-wire bus master for the serial eeprom data pins
// assumes the bench resolves data_line from the pins with a pull-up
`timescale 1ns/100ps
module eew_master
    import eew_pkg::*;
(
    output logic      serial_clock,
    output logic      chip_select,
    output logic      serial_in_line,
    input  wire logic data_line
);
    // link clock stands low outside frames
    initial begin
        serial_clock   = 1'b0;
        chip_select    = 1'b0;
        serial_in_line = 1'b0;
    end

    // ------------------------------------------------------------
    // bit level
    // ------------------------------------------------------------
    // bit before rise
    task automatic bit_io(input logic b, output logic s);
        serial_in_line <= b;
        #32 serial_clock <= 1'b1;
        #31 s = data_line;
        #1 serial_clock <= 1'b0;
    endtask

    task automatic shift(input logic [15:0] v, input int n);
        logic s;
        for (int i = n - 1; i >= 0; i--) begin
            bit_io(v[i], s);
        end
    endtask

    // ------------------------------------------------------------
    // frames
    // ------------------------------------------------------------
    // idle clocks, then start
    task automatic start(input logic [1:0] op);
        #1.3 chip_select <= 1'b1;
        #20 shift({13'h0, 1'b1, op}, 6);
    endtask

    task automatic select_high();
        #1.3 chip_select <= 1'b1;
    endtask

    task automatic stop(input int low_ns);
        #20 chip_select <= 1'b0;
        serial_in_line <= ~serial_in_line;
        #(low_ns);
    endtask

    // the extra rise after the word releases the output
    task automatic read(input logic [6:0] a, input logic wide,
                        output logic [16:0] got);
        int   dl;
        logic s;
        dl = wide ? 16 : 8;
        start(OP_READ);
        shift(16'(a >> 1), wide ? 5 : 6);
        bit_io(a[0], s);
        got = 17'(s);
        for (int i = 0; i < dl; i++) begin
            bit_io(1'b0, s);
            got = {got[15:0], s};
        end
        bit_io(1'b0, s);
        stop(300);
    endtask

    task automatic write(input logic [1:0] op, input logic [6:0] a,
                         input logic wide, input logic [15:0] d,
                         input int low_ns);
        start(op);
        shift({9'h0, a}, wide ? 6 : 7);
        if (op == OP_WRITE) begin
            shift(d, wide ? 16 : 8);
        end
        stop(low_ns);
    endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the serial eeprom data pins
// assumes a pull-up on the output wire and a shortened programming time
`timescale 1ns/100ps
module tb_top
    import eew_pkg::*;
;
    localparam int PROG = 400;
    localparam int CEIL = 40000;

    logic        clock;
    logic        reset_n;
    logic        word_width_select;
    logic        serial_clock;
    logic        chip_select;
    logic        serial_in_line;
    logic        serial_out;
    logic        serial_out_oe_n;
    logic        data_line;
    logic [16:0] got;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    // pull-up on the shared output wire
    assign data_line = serial_out_oe_n ? 1'b1 : serial_out;

    eew_top #(
        .PROG_CYCLES(PROG)
    ) eew_top_i (
        .clock            (clock),
        .reset_n          (reset_n),
        .serial_clock     (serial_clock),
        .chip_select      (chip_select),
        .serial_in_line   (serial_in_line),
        .word_width_select(word_width_select),
        .serial_out       (serial_out),
        .serial_out_oe_n  (serial_out_oe_n)
    );

    eew_master eew_master_i (
        .serial_clock  (serial_clock),
        .chip_select   (chip_select),
        .serial_in_line(serial_in_line),
        .data_line     (data_line)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [16:0] exp,
                         input logic [16:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic quiet(input int cyc);
        int bad;
        bad = 0;
        repeat (cyc) begin
            @(posedge clock);
            if (serial_out_oe_n !== 1'b1) begin
                bad++;
            end
        end
        check("cycles driven", 17'h0, 17'(bad));
    endtask

    // ready expected about PROG cycles after select fell, less the wait
    task automatic status();
        int n;
        eew_master_i.select_high();
        #40;
        check("status enable", 17'h0, 17'(serial_out_oe_n));
        check("status busy", 17'h0, 17'(data_line));
        n = 0;
        while (data_line !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        check("ready delay", 17'h1, 17'(n >= 300 && n <= 380));
        check("ready enable", 17'h0, 17'(serial_out_oe_n));
        eew_master_i.stop(300);
        check("status release", 17'h1, 17'(serial_out_oe_n));
    endtask

    task automatic read_word(input logic [6:0] a, input logic wide,
                             input logic [16:0] exp);
        eew_master_i.read(a, wide, got);
        check("read word", exp, got);
        check("read release", 17'h1, 17'(serial_out_oe_n));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        check("idle enable", 17'h1, 17'(serial_out_oe_n));
    endtask

    task automatic t_write_wide();
        eew_master_i.write(OP_WRITE, 7'h05, 1'b1, 16'hA5C3, 300);
        status();
        read_word(7'h05, 1'b1, {1'b0, 16'hA5C3});
    endtask

    task automatic t_narrow();
        @(posedge clock);
        word_width_select <= 1'b0;
        read_word(7'h0A, 1'b0, 17'h0A5);
        read_word(7'h0B, 1'b0, 17'h0C3);
        eew_master_i.write(OP_WRITE, 7'h0B, 1'b0, 16'h003C, 0);
        quiet(600);
        @(posedge clock);
        word_width_select <= 1'b1;
        read_word(7'h05, 1'b1, {1'b0, 16'hA53C});
    endtask

    task automatic t_erase_brief();
        eew_master_i.write(OP_ERASE, 7'h05, 1'b1, 16'h0, 100);
        eew_master_i.select_high();
        quiet(600);
        eew_master_i.stop(300);
        read_word(7'h05, 1'b1, {1'b0, 16'hFFFF});
    endtask

    task automatic t_erase_status();
        eew_master_i.write(OP_ERASE, 7'h06, 1'b1, 16'h0, 300);
        status();
        read_word(7'h06, 1'b1, {1'b0, 16'hFFFF});
    endtask

    // a frame cut short must leave the decoder waiting for a new start;
    // the word read back was erased earlier, the array has no reset value
    task automatic t_abort();
        eew_master_i.start(OP_READ);
        eew_master_i.shift(16'h0001, 2);
        eew_master_i.stop(300);
        quiet(20);
        read_word(7'h06, 1'b1, {1'b0, 16'hFFFF});
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        reset_n <= 1'b0;
        word_width_select <= 1'b1;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_idle();
        t_write_wide();
        t_narrow();
        t_erase_brief();
        t_erase_status();
        t_abort();
        summarize();
    end

    // a hang counts as a mismatch and still reaches the report
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == CEIL) begin
            mismatches++;
            summarize();
        end
    end
endmodule
